/* shared/asm_consts.svh */
`ifndef ASM_CONSTS_SVH
`define ASM_CONSTS_SVH
`define ASM_ADDR_RESET 7'h00
`define ASM_ADDR_PWR 7'h01
`define ASM_ADDR_TIM 7'h02
`define ASM_ADDR_OMODE 7'h03
`define ASM_ADDR_DFMT 7'h04
`define ASM_REG_RESET_VAL 8'h00
`define ASM_READ_NONE 8'h00
`define ASM_SRST_BIT 7
`define ASM_PD_MSB 1
`define ASM_PD_LSB 0
`define ASM_TIM_INV_BIT 3
`define ASM_TIM_DLY_MSB 2
`define ASM_TIM_DLY_LSB 1
`define ASM_TIM_DCS_BIT 0
`define ASM_PD_RUN 2'h0
`define ASM_PD_NAP2 2'h1
`define ASM_PD_NAPALL 2'h2
`define ASM_PD_SLEEP 2'h3
`define ASM_DLY_NONE 2'h0
`define ASM_FRAME_BITS 5'h10
`define ASM_LAST_BIT 5'h0f
`define ASM_HDR_BITS 5'h08
`define ASM_CNT_ONE 5'h01
`define ASM_SYS_CLK_KHZ 10000
`define ASM_SRST_SLEEP_NS 500
`define ASM_SRST_SLEEP_CYC ((`ASM_SRST_SLEEP_NS * `ASM_SYS_CLK_KHZ + 999999) / 1000000)
`define ASM_SLEEP_ONE 4'h1
`define ASM_SLEEP_ZERO 4'h0
`endif

/* shared/asm_pkg.sv */
`default_nettype none
package asm_pkg;
    typedef struct packed {
        logic rd;
        logic [6:0] addr;
        logic [7:0] data;
    } asm_frame_t;
    typedef struct packed {
        logic [7:0] pwr;
        logic [7:0] tim;
        logic [7:0] omode;
        logic [7:0] dfmt;
    } asm_bank_t;
endpackage
`default_nettype wire

/* shared/asm_link_if.sv */
`default_nettype none
interface asm_link_if;
    // word and toggle: sck domain; bank: system domain, static during frames
    asm_pkg::asm_frame_t word;
    logic done_tgl;
    asm_pkg::asm_bank_t bank;
    modport link (
        output word,
        output done_tgl,
        input bank
    );
    modport core (
        input word,
        input done_tgl,
        output bank
    );
endinterface
`default_nettype wire

/* logic/asm_serial_link.sv */
`include "asm_consts.svh"
`default_nettype none
module asm_serial_link (
    input wire logic sck_in, // serial clock from host
    input wire logic cs_n_in, // frame select, active low
    input wire logic resetn_in, // async reset, active low
    input wire logic sdi_in, // serial data in
    output logic sdo_oe_n_out, // low while pulling sdo low
    asm_link_if.link lnk // to register core
);
    logic [4:0] cnt_ff;
    logic [14:0] sr_ff;
    logic [7:0] out_ff;
    logic oe_n_ff;
    logic rd_ff;
    logic tgl_ff;
    asm_pkg::asm_frame_t word_ff;
    logic [7:0] rdata;
    wire logic [6:0] hdr_addr = sr_ff[6:0];
    wire logic hdr_rd = sr_ff[7];
    wire logic in_frame = (cnt_ff != `ASM_FRAME_BITS);
    wire logic last_edge = (cnt_ff == `ASM_LAST_BIT);
    wire logic hdr_done = (cnt_ff == `ASM_HDR_BITS);
    wire logic data_phase = (cnt_ff > `ASM_HDR_BITS) && in_frame;

    assign rdata = (hdr_addr == `ASM_ADDR_PWR) ? lnk.bank.pwr :
                   (hdr_addr == `ASM_ADDR_TIM) ? lnk.bank.tim :
                   (hdr_addr == `ASM_ADDR_OMODE) ? lnk.bank.omode :
                   (hdr_addr == `ASM_ADDR_DFMT) ? lnk.bank.dfmt : `ASM_READ_NONE;

    // chip select high ends the frame and clears the count
    always_ff @(posedge sck_in or posedge cs_n_in) begin
        if (cs_n_in) begin
            cnt_ff <= 5'h00;
            sr_ff <= 15'h0000;
        end else if (in_frame) begin
            cnt_ff <= cnt_ff + `ASM_CNT_ONE;
            sr_ff <= {sr_ff[13:0], sdi_in};
        end
    end

    // word held across frames, so not cleared by chip select
    always_ff @(posedge sck_in or negedge resetn_in) begin
        if (!resetn_in) begin
            word_ff <= 16'h0000;
            tgl_ff <= 1'b0;
        end else if (!cs_n_in && last_edge) begin
            word_ff <= {sr_ff, sdi_in};
            tgl_ff <= ~tgl_ff;
        end
    end

    // read data changes on falling edges, host samples on rising
    always_ff @(negedge sck_in or posedge cs_n_in) begin
        if (cs_n_in) begin
            oe_n_ff <= 1'b1;
            out_ff <= 8'h00;
            rd_ff <= 1'b0;
        end else if (hdr_done) begin
            rd_ff <= hdr_rd;
            oe_n_ff <= hdr_rd ? rdata[7] : 1'b1;
            out_ff <= {rdata[6:0], 1'b0};
        end else if (data_phase && rd_ff) begin
            oe_n_ff <= out_ff[7];
            out_ff <= {out_ff[6:0], 1'b0};
        end else begin
            oe_n_ff <= 1'b1;
        end
    end

    assign lnk.word = word_ff;
    assign lnk.done_tgl = tgl_ff;
    assign sdo_oe_n_out = oe_n_ff;

    cnt_sat_a: assert property (@(posedge sck_in) disable iff (cs_n_in)
        cnt_ff == `ASM_FRAME_BITS |=> cnt_ff == `ASM_FRAME_BITS && $stable(word_ff))
        else $error("edge after sixteenth bit was not ignored");
    tgl_cause_a: assert property (@(posedge sck_in) disable iff (!resetn_in)
        tgl_ff != $past(tgl_ff) |-> $past(cnt_ff) == `ASM_LAST_BIT)
        else $error("frame completed without sixteen bits");
endmodule
`default_nettype wire

/* logic/asm_mode_regs.sv */
`include "asm_consts.svh"
`default_nettype none
// Notes on behaviour
// - writing one to bit 7 at address zero clears all mode registers.
// - software reset briefly forces full sleep before resuming cleared.
// - reset bit is never stored, so it reads back zero after the write.
// - reset register is write only; low seven bits ignored on write.
// - power-down field 00 run, 01 channel two nap, 10 both nap, 11 sleep.
// - timing bit 3 inverts output clock polarity; bits 7 to 4 ignored.
// - timing bits 2:1 delay output clock by 0, 1/8, 1/4 or 3/8 period.
// - timing bit 0 enables the input clock duty cycle stabilizer.
// - output mode register at three, data format register at four.
// - frame is sixteen bits msb first: read flag, address, data.
// - chip select low starts a frame; only first sixteen edges sampled.
// - read frames shift register out and leave registers unchanged.
module asm_mode_regs (
    input wire logic clk_sys_in, // system clock, 10 MHz
    input wire logic resetn_in, // async reset, active low
    input wire logic sck_in, // serial clock from host
    input wire logic cs_n_in, // frame select, active low
    input wire logic sdi_in, // serial data in
    output logic sdo_out, // open-drain data level, always low
    output logic sdo_oe_n_out, // low while pulling sdo low
    output logic [1:0] power_down_sel_out, // stored power-down field
    output logic nap_ch1_out, // channel one napping
    output logic nap_ch2_out, // channel two napping
    output logic sleep_out, // whole converter asleep
    output logic out_clock_invert_out, // output clock inverted
    output logic [1:0] out_clock_delay_out, // output clock delay in eighths
    output logic duty_cycle_stabilizer_en_out, // stabilizer on
    output logic [7:0] output_mode_out, // output mode register
    output logic [7:0] data_format_out // data format register
);
    localparam logic [3:0] SLEEP_CYC = 4'(`ASM_SRST_SLEEP_CYC);

    asm_link_if lnk ();

    asm_serial_link u_link (
        .sck_in(sck_in),
        .cs_n_in(cs_n_in),
        .resetn_in(resetn_in),
        .sdi_in(sdi_in),
        .sdo_oe_n_out(sdo_oe_n_out),
        .lnk(lnk.link)
    );

    logic tgl_s1_ff;
    logic tgl_s2_ff;
    logic tgl_s3_ff;
    logic [7:0] pwr_ff;
    logic [7:0] tim_ff;
    logic [7:0] omode_ff;
    logic [7:0] dfmt_ff;
    logic [3:0] sleep_cnt_ff;
    logic [1:0] pd_out_ff;
    logic nap1_ff;
    logic nap2_ff;
    logic sleep_ff;
    logic inv_ff;
    logic [1:0] dly_ff;
    logic dcs_ff;
    logic [7:0] omode_out_ff;
    logic [7:0] dfmt_out_ff;

    // frame done toggle crosses by two flops; third flop finds the edge
    always_ff @(posedge clk_sys_in or negedge resetn_in) begin
        if (!resetn_in) begin
            tgl_s1_ff <= 1'b0;
            tgl_s2_ff <= 1'b0;
            tgl_s3_ff <= 1'b0;
        end else begin
            tgl_s1_ff <= lnk.done_tgl;
            tgl_s2_ff <= tgl_s1_ff;
            tgl_s3_ff <= tgl_s2_ff;
        end
    end

    // word held stable by the link until the next full frame
    asm_pkg::asm_frame_t frm;
    assign frm = lnk.word;

    wire logic frame_evt = tgl_s2_ff ^ tgl_s3_ff;
    wire logic wr_evt = frame_evt && !frm.rd;
    wire logic wr_reset = wr_evt && (frm.addr == `ASM_ADDR_RESET);
    wire logic srst = wr_reset && frm.data[`ASM_SRST_BIT];
    wire logic wr_pwr = wr_evt && (frm.addr == `ASM_ADDR_PWR);
    wire logic wr_tim = wr_evt && (frm.addr == `ASM_ADDR_TIM);
    wire logic wr_omode = wr_evt && (frm.addr == `ASM_ADDR_OMODE);
    wire logic wr_dfmt = wr_evt && (frm.addr == `ASM_ADDR_DFMT);

    // one rule for all four registers: software reset beats a write
    function automatic logic [7:0] reg_next(input logic clr, input logic wr,
                                            input logic [7:0] data, input logic [7:0] cur);
        logic [7:0] val;
        val = cur;
        if (clr) begin
            val = `ASM_REG_RESET_VAL;
        end else if (wr) begin
            val = data;
        end
        return val;
    endfunction

    // reset bit never stored: nothing to clear afterwards
    wire logic [7:0] nxt_pwr_ff = reg_next(srst, wr_pwr, frm.data, pwr_ff);
    wire logic [7:0] nxt_tim_ff = reg_next(srst, wr_tim, frm.data, tim_ff);
    wire logic [7:0] nxt_omode_ff = reg_next(srst, wr_omode, frm.data, omode_ff);
    wire logic [7:0] nxt_dfmt_ff = reg_next(srst, wr_dfmt, frm.data, dfmt_ff);

    always_ff @(posedge clk_sys_in or negedge resetn_in) begin
        if (!resetn_in) begin
            pwr_ff <= `ASM_REG_RESET_VAL;
            tim_ff <= `ASM_REG_RESET_VAL;
            omode_ff <= `ASM_REG_RESET_VAL;
            dfmt_ff <= `ASM_REG_RESET_VAL;
        end else begin
            pwr_ff <= nxt_pwr_ff;
            tim_ff <= nxt_tim_ff;
            omode_ff <= nxt_omode_ff;
            dfmt_ff <= nxt_dfmt_ff;
        end
    end

    // short sleep window on software reset; analog side sees full sleep
    wire logic sleep_busy = (sleep_cnt_ff != `ASM_SLEEP_ZERO);
    wire logic [3:0] nxt_sleep_cnt_ff = srst ? SLEEP_CYC :
                                        sleep_busy ? sleep_cnt_ff - `ASM_SLEEP_ONE :
                                        sleep_cnt_ff;

    always_ff @(posedge clk_sys_in or negedge resetn_in) begin
        if (!resetn_in) begin
            sleep_cnt_ff <= `ASM_SLEEP_ZERO;
        end else begin
            sleep_cnt_ff <= nxt_sleep_cnt_ff;
        end
    end

    // power-down decode of the next stored field
    wire logic [1:0] pd_sel = nxt_pwr_ff[`ASM_PD_MSB:`ASM_PD_LSB];
    wire logic force_sleep = srst || (nxt_sleep_cnt_ff != `ASM_SLEEP_ZERO);
    wire logic nxt_sleep_ff = force_sleep || (pd_sel == `ASM_PD_SLEEP);
    wire logic nxt_nap1_ff = !nxt_sleep_ff && (pd_sel == `ASM_PD_NAPALL);
    wire logic nxt_nap2_ff = !nxt_sleep_ff &&
                             ((pd_sel == `ASM_PD_NAPALL) || (pd_sel == `ASM_PD_NAP2));

    // timing fields; upper bits of the timing byte are ignored
    wire logic nxt_inv_ff = nxt_tim_ff[`ASM_TIM_INV_BIT];
    wire logic [1:0] nxt_dly_ff = nxt_tim_ff[`ASM_TIM_DLY_MSB:`ASM_TIM_DLY_LSB];
    wire logic nxt_dcs_ff = nxt_tim_ff[`ASM_TIM_DCS_BIT];

    // outputs from flops, aligned with the stored registers
    always_ff @(posedge clk_sys_in or negedge resetn_in) begin
        if (!resetn_in) begin
            pd_out_ff <= `ASM_PD_RUN;
            sleep_ff <= 1'b0;
            nap1_ff <= 1'b0;
            nap2_ff <= 1'b0;
            inv_ff <= 1'b0;
            dly_ff <= `ASM_DLY_NONE;
            dcs_ff <= 1'b0;
            omode_out_ff <= `ASM_REG_RESET_VAL;
            dfmt_out_ff <= `ASM_REG_RESET_VAL;
        end else begin
            pd_out_ff <= pd_sel;
            sleep_ff <= nxt_sleep_ff;
            nap1_ff <= nxt_nap1_ff;
            nap2_ff <= nxt_nap2_ff;
            inv_ff <= nxt_inv_ff;
            dly_ff <= nxt_dly_ff;
            dcs_ff <= nxt_dcs_ff;
            omode_out_ff <= nxt_omode_ff;
            dfmt_out_ff <= nxt_dfmt_ff;
        end
    end

    // read bank: only changes after a frame has ended
    assign lnk.bank = {pwr_ff, tim_ff, omode_ff, dfmt_ff};

    assign sdo_out = 1'b0;
    assign power_down_sel_out = pd_out_ff;
    assign nap_ch1_out = nap1_ff;
    assign nap_ch2_out = nap2_ff;
    assign sleep_out = sleep_ff;
    assign out_clock_invert_out = inv_ff;
    assign out_clock_delay_out = dly_ff;
    assign duty_cycle_stabilizer_en_out = dcs_ff;
    assign output_mode_out = omode_out_ff;
    assign data_format_out = dfmt_out_ff;

    srst_clear_a: assert property (
        @(posedge clk_sys_in) disable iff (!resetn_in)
        srst |=> pwr_ff == `ASM_REG_RESET_VAL && tim_ff == `ASM_REG_RESET_VAL &&
                 omode_ff == `ASM_REG_RESET_VAL && dfmt_ff == `ASM_REG_RESET_VAL)
        else $error("software reset left a register nonzero");

    srst_zero_a: assert property (
        @(posedge clk_sys_in) disable iff (!resetn_in)
        wr_reset && !frm.data[`ASM_SRST_BIT] |=>
            $stable(pwr_ff) && $stable(tim_ff) && $stable(omode_ff) && $stable(dfmt_ff))
        else $error("zero write to reset register changed state");

    srst_low_bits_a: assert property (
        @(posedge clk_sys_in) disable iff (!resetn_in)
        wr_reset && frm.data[`ASM_SRST_BIT] |-> srst)
        else $error("reset register low bits blocked the reset");

    srst_sleep_a: assert property (
        @(posedge clk_sys_in) disable iff (!resetn_in)
        srst |=> sleep_out && !nap_ch1_out && !nap_ch2_out)
        else $error("software reset did not enter sleep");

    srst_wake_a: assert property (
        @(posedge clk_sys_in) disable iff (!resetn_in)
        srst ##1 !frame_evt [*5] |=> !sleep_out)
        else $error("sleep after software reset did not end");

    srst_once_a: assert property (
        @(posedge clk_sys_in) disable iff (!resetn_in)
        srst |=> !srst)
        else $error("reset bit did not clear after its write");

    pd_write_a: assert property (
        @(posedge clk_sys_in) disable iff (!resetn_in)
        wr_pwr |=> power_down_sel_out == $past(frm.data[`ASM_PD_MSB:`ASM_PD_LSB]))
        else $error("power-down field not stored");

    pd_nap2_a: assert property (
        @(posedge clk_sys_in) disable iff (!resetn_in)
        power_down_sel_out == `ASM_PD_NAP2 && sleep_cnt_ff == `ASM_SLEEP_ZERO |->
            nap_ch2_out && !nap_ch1_out && !sleep_out)
        else $error("single channel nap decode wrong");

    pd_sleep_a: assert property (
        @(posedge clk_sys_in) disable iff (!resetn_in)
        power_down_sel_out == `ASM_PD_SLEEP |-> sleep_out && !nap_ch1_out)
        else $error("sleep decode wrong");

    clk_invert_a: assert property (
        @(posedge clk_sys_in) disable iff (!resetn_in)
        wr_tim && !srst |=> out_clock_invert_out == $past(frm.data[`ASM_TIM_INV_BIT]))
        else $error("output clock invert not taken from bit 3");

    clk_delay_a: assert property (
        @(posedge clk_sys_in) disable iff (!resetn_in)
        wr_tim |=> out_clock_delay_out == $past(frm.data[`ASM_TIM_DLY_MSB:`ASM_TIM_DLY_LSB]))
        else $error("output clock delay not taken from bits 2:1");

    dcs_enable_a: assert property (
        @(posedge clk_sys_in) disable iff (!resetn_in)
        wr_tim |=> duty_cycle_stabilizer_en_out == $past(frm.data[`ASM_TIM_DCS_BIT]))
        else $error("stabilizer enable not taken from bit 0");

    extra_regs_a: assert property (
        @(posedge clk_sys_in) disable iff (!resetn_in)
        wr_omode |=> output_mode_out == $past(frm.data) && $stable(data_format_out))
        else $error("output mode register write wrong");

    fmt_reg_a: assert property (
        @(posedge clk_sys_in) disable iff (!resetn_in)
        wr_dfmt |=> data_format_out == $past(frm.data) && $stable(output_mode_out))
        else $error("data format register write wrong");

    read_keep_a: assert property (
        @(posedge clk_sys_in) disable iff (!resetn_in)
        frame_evt && frm.rd |=>
            $stable(pwr_ff) && $stable(tim_ff) && $stable(omode_ff) && $stable(dfmt_ff))
        else $error("read frame changed a register");

    no_frame_a: assert property (
        @(posedge clk_sys_in) disable iff (!resetn_in)
        !frame_evt |=> $stable(pwr_ff) && $stable(tim_ff) && $stable(omode_ff) && $stable(dfmt_ff))
        else $error("register changed without a full frame");

    frame_pulse_a: assert property (
        @(posedge clk_sys_in) disable iff (!resetn_in)
        $changed(tgl_s3_ff) |-> $past(frame_evt))
        else $error("completed frame not seen once");

    srst_outputs_a: assert property (
        @(posedge clk_sys_in) disable iff (!resetn_in)
        srst |=> power_down_sel_out == `ASM_PD_RUN && !out_clock_invert_out &&
                 out_clock_delay_out == `ASM_DLY_NONE && !duty_cycle_stabilizer_en_out &&
                 output_mode_out == `ASM_REG_RESET_VAL && data_format_out == `ASM_REG_RESET_VAL)
        else $error("software reset left an output set");

    srst_window_a: assert property (
        @(posedge clk_sys_in) disable iff (!resetn_in)
        srst |=> sleep_out [*5])
        else $error("sleep window after software reset too short");

    pd_napall_a: assert property (
        @(posedge clk_sys_in) disable iff (!resetn_in)
        power_down_sel_out == `ASM_PD_NAPALL && sleep_cnt_ff == `ASM_SLEEP_ZERO |->
            nap_ch1_out && nap_ch2_out && !sleep_out)
        else $error("both channel nap decode wrong");

    pd_run_a: assert property (
        @(posedge clk_sys_in) disable iff (!resetn_in)
        power_down_sel_out == `ASM_PD_RUN && sleep_cnt_ff == `ASM_SLEEP_ZERO |->
            !nap_ch1_out && !nap_ch2_out && !sleep_out)
        else $error("normal operation decode wrong");

    nap_order_a: assert property (
        @(posedge clk_sys_in) disable iff (!resetn_in)
        nap_ch1_out |-> nap_ch2_out)
        else $error("channel one napping while channel two runs");

    sleep_no_nap_a: assert property (
        @(posedge clk_sys_in) disable iff (!resetn_in)
        sleep_out |-> !nap_ch1_out && !nap_ch2_out)
        else $error("nap flag set during full sleep");

    evt_single_a: assert property (
        @(posedge clk_sys_in) disable iff (!resetn_in)
        frame_evt |=> !frame_evt)
        else $error("one frame seen as two events");

    out_keep_a: assert property (
        @(posedge clk_sys_in) disable iff (!resetn_in)
        !frame_evt |=> $stable(power_down_sel_out) && $stable(out_clock_invert_out) &&
            $stable(out_clock_delay_out) && $stable(duty_cycle_stabilizer_en_out) &&
            $stable(output_mode_out) && $stable(data_format_out))
        else $error("output changed without a full frame");

    read_outputs_a: assert property (
        @(posedge clk_sys_in) disable iff (!resetn_in)
        frame_evt && frm.rd |=> $stable(power_down_sel_out) && $stable(out_clock_delay_out) &&
            $stable(output_mode_out) && $stable(data_format_out))
        else $error("read frame changed an output");

    pwr_only_a: assert property (
        @(posedge clk_sys_in) disable iff (!resetn_in)
        wr_pwr |=> $stable(output_mode_out) && $stable(data_format_out) &&
            $stable(out_clock_delay_out))
        else $error("power-down write reached another register");

    tim_only_a: assert property (
        @(posedge clk_sys_in) disable iff (!resetn_in)
        wr_tim |=> $stable(power_down_sel_out) && $stable(output_mode_out) &&
            $stable(data_format_out))
        else $error("timing write reached another register");
endmodule
`default_nettype wire

/* dv/asm_host_model.sv */
`default_nettype none
module asm_host_model (
    output var logic sck_out, // serial clock, low outside frames
    output var logic cs_n_out, // frame select, active low
    output var logic sdi_out, // serial data to device
    input wire logic sdo_in // resolved open-drain line, pulled up
);
    timeunit 1ns;
    timeprecision 100ps;
    initial begin
        sck_out = 1'b0;
        cs_n_out = 1'b0;
        sdi_out = 1'b0;
        // one rising select at start clears the link's frame state
        #1 cs_n_out = 1'b1;
    end
    // edges past the sixteenth carry filler that must be ignored
    task automatic xfer(input logic [15:0] word, input int nbits, output logic [7:0] rdata);
        rdata = 8'h00;
        cs_n_out = 1'b0;
        for (int i = 0; i < nbits; i++) begin
            sdi_out = (i < 16) ? word[15 - i] : ~word[0];
            #7.5 sck_out = 1'b1;
            if (i >= 8 && i < 16) begin
                rdata = {rdata[6:0], sdo_in};
            end
            #7.5 sck_out = 1'b0;
        end
        #7.5 cs_n_out = 1'b1;
        sdi_out = ~sdi_out;
    endtask
endmodule
`default_nettype wire

/* dv/adc_serial_mode_registers_tb.sv */
`default_nettype none
module adc_serial_mode_registers_tb;
    timeunit 1ns;
    timeprecision 100ps;
    logic clk_sys = 1'b0;
    logic resetn = 1'b1;
    wire logic sck, cs_n, sdi, sdo, sdo_oe_n, nap1, nap2, sleep, inv, duty_cycle_stabilizer_en;
    wire logic [1:0] pd_sel, dly;
    wire logic [7:0] omode, dfmt;
    wire logic sdo_line;
    int err_count = 0;
    int n_compared = 0;
    logic [7:0] r;
    // pull-up wins whenever the device lets go of the line
    assign sdo_line = (sdo_oe_n === 1'b0) ? sdo : 1'b1;
    asm_mode_regs dut (
        .clk_sys_in(clk_sys), .resetn_in(resetn), .sck_in(sck), .cs_n_in(cs_n),
        .sdi_in(sdi), .sdo_out(sdo), .sdo_oe_n_out(sdo_oe_n),
        .power_down_sel_out(pd_sel), .nap_ch1_out(nap1), .nap_ch2_out(nap2),
        .sleep_out(sleep), .out_clock_invert_out(inv), .out_clock_delay_out(dly),
        .duty_cycle_stabilizer_en_out(duty_cycle_stabilizer_en), .output_mode_out(omode),
        .data_format_out(dfmt)
    );
    asm_host_model host (.sck_out(sck), .cs_n_out(cs_n), .sdi_out(sdi), .sdo_in(sdo_line));
    initial begin
        forever #50 clk_sys = ~clk_sys;
    end
    task automatic end_sim();
        if (err_count == 0 && n_compared > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask
    task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
        n_compared++;
        if (seen !== exp) begin
            err_count++;
            $display("wrong value %s expected %h seen %h", name, exp, seen);
        end
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge clk_sys);
        #2;
    endtask
    // gap of six system cycles keeps frames over 500 ns apart
    task automatic wr(input logic [6:0] a, input logic [7:0] d);
        logic [7:0] x;
        host.xfer({1'b0, a, d}, 16, x);
        cyc(6);
    endtask
    task automatic rd(input logic [6:0] a, output logic [7:0] d);
        host.xfer({1'b1, a, 8'h5a}, 16, d);
        cyc(6);
    endtask
    task automatic chk_pd(input logic [1:0] f);
        check("power", {3'h0, pd_sel, nap1, nap2, sleep},
            {3'h0, f, f == 2'h2, f != 2'h0 && f != 2'h3, f == 2'h3});
    endtask
    task automatic t_after_reset();
        chk_pd(2'h0);
        check("timing", {4'h0, inv, dly, duty_cycle_stabilizer_en}, 8'h00);
        check("omode", omode, 8'h00);
        check("dfmt", dfmt, 8'h00);
        check("oe_n", {7'h00, sdo_oe_n}, 8'h01);
    endtask
    task automatic t_soft_reset();
        int n;
        wr(7'h00, 8'h80);
        wr(7'h01, 8'h02);
        wr(7'h02, 8'h0f);
        wr(7'h03, 8'hc3);
        wr(7'h04, 8'h3c);
        wr(7'h00, 8'h7f);
        check("omode", omode, 8'hc3);
        host.xfer({1'b0, 7'h00, 8'hff}, 16, r);
        for (n = 0; n < 8 && sleep !== 1'b1; n++) cyc(1);
        cyc(0);
        check("pd_field", {6'h00, pd_sel}, 8'h00);
        check("timing", {4'h0, inv, dly, duty_cycle_stabilizer_en}, 8'h00);
        check("omode", omode, 8'h00);
        check("dfmt", dfmt, 8'h00);
        for (n = 0; n < 20 && sleep === 1'b1; n++) cyc(1);
        check("sleep_len", n[7:0], 8'h05);
        chk_pd(2'h0);
        rd(7'h00, r);
        check("rst_read", r, 8'h00);
        wr(7'h03, 8'h11);
        check("omode", omode, 8'h11);
    endtask
    task automatic t_power();
        for (int f = 0; f < 4; f++) begin
            wr(7'h01, 8'hfc | f[7:0]);
            chk_pd(f[1:0]);
            rd(7'h01, r);
            check("pd_read", r & 8'h03, f[7:0]);
        end
    endtask
    task automatic t_timing();
        logic [7:0] v[8] = '{8'hf0, 8'hf1, 8'hf8, 8'hf9, 8'hf3, 8'hf5, 8'hf7, 8'hff};
        foreach (v[i]) begin
            wr(7'h02, v[i]);
            check("timing", {4'h0, inv, dly, duty_cycle_stabilizer_en}, v[i] & 8'h0f);
            rd(7'h02, r);
            check("tim_read", r & 8'h0f, v[i] & 8'h0f);
        end
    endtask
    task automatic t_map();
        wr(7'h03, 8'ha5);
        wr(7'h04, 8'h5a);
        check("omode", omode, 8'ha5);
        check("dfmt", dfmt, 8'h5a);
        rd(7'h03, r);
        check("om_read", r, 8'ha5);
        rd(7'h04, r);
        check("df_read", r, 8'h5a);
        check("dfmt", dfmt, 8'h5a);
        wr(7'h05, 8'hff);
        check("omode", omode, 8'ha5);
        rd(7'h7f, r);
        check("unmapped", r, 8'h00);
    endtask
    task automatic t_frames();
        host.xfer({1'b0, 7'h03, 8'h00}, 10, r);
        cyc(6);
        check("omode", omode, 8'ha5);
        host.xfer({1'b0, 7'h03, 8'h3c}, 20, r);
        cyc(6);
        check("omode", omode, 8'h3c);
        check("oe_n", {7'h00, sdo_oe_n}, 8'h01);
    endtask
    initial begin
        // a real falling edge, so the serial-clocked flops see their reset
        #1 resetn = 1'b0;
        cyc(2);
        resetn = 1'b1;
        cyc(2);
        t_after_reset();
        t_soft_reset();
        t_power();
        t_timing();
        t_map();
        t_frames();
        end_sim();
    end
    initial begin
        #200000;
        err_count++;
        end_sim();
    end
endmodule
`default_nettype wire
